/* File: hw/sps_pkg.sv */
// Shared constants and types for the pipelined burst SRAM core.
package sps_pkg;
  localparam int unsigned ADDR_W     = 19;
  localparam int unsigned LANES      = 8;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned DQ_W       = 64;
  localparam int unsigned WORD_W     = 72;
  localparam int unsigned BURST_LEN  = 4;
  // Register map, byte addresses on the bus.
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_WRCNT   = 8'h08;
  // Control fields.
  localparam int unsigned CTRL_SLEEP  = 0;
  localparam int unsigned CTRL_NODRV  = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  // Status fields.
  localparam int unsigned ST_SLEEP    = 0;
  localparam int unsigned ST_ILEAVE   = 1;
  localparam int unsigned ST_CNT_LO   = 2;
  localparam int unsigned ST_BURST    = 4;
  localparam int unsigned ST_DRIVE    = 5;
  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001, TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004, TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010, TAP_EX1_DR  = 16'h0020,
    TAP_PA_DR   = 16'h0040, TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100, TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400, TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000, TAP_PA_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000, TAP_UPD_IR  = 16'h8000
  } sps_tap_t;
endpackage

/* File: hw/sps_sram_core.sv */
// Pipelined burst SRAM core with pin control, test port and AHB-Lite regs.
// Notes on behaviour
// - Output enable high forces data pins to input.
// - Tri-state on write data, after deselect, deselected.
// - Clock edge acts only when qualify low.
// - Qualify high stretches cycle, never deselects.
// - Input data captured on rising clock edge.
// - Read drives data of previously sampled address.
// - Parity pins behave exactly like data pins.
// - Strap high interleaved, low linear order.
// - Unconnected strap behaves as high, interleaved.
// - Test serial output changes on falling edge.
// - Test serial input sampled on rising edge.
// - Mode select advances test state machine.
// - Sleep input idles device, memory kept.
// - Advance high steps counter, low loads address.
// - Counter uses two low bits, wraps after four.
`timescale 1ns/1ps
`default_nettype none
module sps_sram_core #(
  parameter int unsigned ADDR_W = sps_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [7:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Memory control pins
  input  wire logic                      clk_qualify_n,
  input  wire logic                      advance_or_load,
  input  wire logic                      we_n,
  input  wire logic                      ce1_n,
  input  wire logic                      ce2,
  input  wire logic                      ce3_n,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [sps_pkg::LANES-1:0] byte_lane_write_n,
  input  wire logic                      oe_n,
  input  wire logic                      sleep_req,
  input  wire logic                      mode_tied,
  input  wire logic                      mode_level,
  // Data and parity pins
  input  wire logic [sps_pkg::DQ_W-1:0]  data_i,
  output logic      [sps_pkg::DQ_W-1:0]  data_o,
  output logic                           data_oe,
  input  wire logic [sps_pkg::LANES-1:0] parity_i,
  output logic      [sps_pkg::LANES-1:0] parity_o,
  output logic                           parity_oe,
  // Test port
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo
);
  localparam int unsigned NL = sps_pkg::LANES;
  localparam int unsigned LW = sps_pkg::LANE_W;
  localparam int unsigned WW = sps_pkg::WORD_W;

  function automatic logic [WW-1:0] pack(input logic [sps_pkg::DQ_W-1:0] d,
                                         input logic [NL-1:0] p);
    logic [WW-1:0] w;
    w = '0;
    for (int k = 0; k < NL; k++) begin
      w[k*LW +: LW] = {p[k], d[k*8 +: 8]};
    end
    return w;
  endfunction

  function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_w,
                                          input logic [WW-1:0] new_w,
                                          input logic [NL-1:0] lane_n);
    logic [WW-1:0] w;
    w = old_w;
    for (int k = 0; k < NL; k++) begin
      if (!lane_n[k]) begin
        w[k*LW +: LW] = new_w[k*LW +: LW];
      end
    end
    return w;
  endfunction

  logic [WW-1:0]     mem [0:(1<<ADDR_W)-1];
  logic [1:0]        ctrl_q;
  logic [31:0]       wrcnt_q;
  logic              strap_done_q;
  logic              mode_q;
  logic              sleeping;
  logic              act;
  logic              load;
  logic              sel;
  logic              burst_q;
  logic              burst_wr_q;
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        cnt_q;
  logic [1:0]        idx;
  logic              a_valid_q;
  logic              a_write_q;
  logic [ADDR_W-1:0] a_addr_q;
  logic [NL-1:0]     a_bw_q;
  logic              b_wr_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [NL-1:0]     b_bw_q;
  logic [WW-1:0]     in_word;
  logic [WW-1:0]     din_q;
  logic [WW-1:0]     rd_word;
  logic              rd_drive_q;
  logic              rd_drive_d;

  assign sleeping = sleep_req | ctrl_q[sps_pkg::CTRL_SLEEP];
  assign act      = !clk_qualify_n && !sleeping;
  assign load     = !advance_or_load;
  assign sel      = !ce1_n && ce2 && !ce3_n;
  assign in_word  = pack(data_i, parity_i);

  // The strap is caught once after reset release and then held.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      mode_q       <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_q       <= mode_tied ? mode_level : 1'b1;
    end
  end

  always_comb begin
    if (mode_q) begin
      idx = base_q[1:0] ^ cnt_q;
    end else begin
      idx = base_q[1:0] + cnt_q;
    end
  end

  // Address stage: load a new access or step the burst counter.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_q    <= 1'b0;
      burst_wr_q <= 1'b0;
      base_q     <= '0;
      cnt_q      <= 2'h0;
      a_valid_q  <= 1'b0;
      a_write_q  <= 1'b0;
      a_addr_q   <= '0;
      a_bw_q     <= '1;
    end else if (act) begin
      a_bw_q <= byte_lane_write_n;
      if (load) begin
        burst_q    <= sel;
        burst_wr_q <= !we_n;
        base_q     <= addr;
        cnt_q      <= 2'h0;
        a_valid_q  <= sel;
        a_write_q  <= !we_n;
        a_addr_q   <= addr;
      end else if (burst_q) begin
        cnt_q     <= cnt_q + 2'h1;
        a_valid_q <= 1'b1;
        a_write_q <= burst_wr_q;
        a_addr_q  <= {base_q[ADDR_W-1:2], mode_q ? (base_q[1:0] ^ (cnt_q + 2'h1))
                                                 : (idx + 2'h1)};
      end else begin
        a_valid_q <= 1'b0;
      end
    end
  end

  // Write data stage and input data register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_wr_q   <= 1'b0;
      b_addr_q <= '0;
      b_bw_q   <= '1;
      din_q    <= '0;
    end else if (act) begin
      b_wr_q   <= a_valid_q && a_write_q;
      b_addr_q <= a_addr_q;
      b_bw_q   <= a_bw_q;
      if (!data_oe) begin
        din_q <= in_word;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (act && b_wr_q) begin
      mem[b_addr_q] <= merge(mem[b_addr_q], in_word, b_bw_q);
    end
  end

  // A read issued right behind a write to the same word sees the new lanes.
  always_comb begin
    rd_word = mem[a_addr_q];
    if (b_wr_q && b_addr_q == a_addr_q) begin
      rd_word = merge(rd_word, in_word, b_bw_q);
    end
  end

  assign rd_drive_d = act ? (a_valid_q && !a_write_q) : rd_drive_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_drive_q <= 1'b0;
      data_o     <= '0;
      parity_o   <= '0;
    end else if (act) begin
      rd_drive_q <= rd_drive_d;
      if (a_valid_q && !a_write_q) begin
        for (int k = 0; k < NL; k++) begin
          data_o[k*8 +: 8] <= rd_word[k*LW +: 8];
          parity_o[k]      <= rd_word[k*LW + 8];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_oe   <= 1'b0;
      parity_oe <= 1'b0;
    end else begin
      data_oe   <= rd_drive_d && !oe_n && !sleeping
                   && !ctrl_q[sps_pkg::CTRL_NODRV];
      parity_oe <= rd_drive_d && !oe_n && !sleeping
                   && !ctrl_q[sps_pkg::CTRL_NODRV];
    end
  end

  // Test port, running on sampled edges of the test clock.
  logic               tck_q;
  logic               tck_rise;
  logic               tck_fall;
  logic               byp_q;
  sps_pkg::sps_tap_t  tap_q;
  sps_pkg::sps_tap_t  tap_d;

  assign tck_rise = tck && !tck_q;
  assign tck_fall = !tck && tck_q;

  always_comb begin
    unique case (tap_q)
      sps_pkg::TAP_RESET:  tap_d = tms ? sps_pkg::TAP_RESET  : sps_pkg::TAP_IDLE;
      sps_pkg::TAP_IDLE:   tap_d = tms ? sps_pkg::TAP_SEL_DR : sps_pkg::TAP_IDLE;
      sps_pkg::TAP_SEL_DR: tap_d = tms ? sps_pkg::TAP_SEL_IR : sps_pkg::TAP_CAP_DR;
      sps_pkg::TAP_CAP_DR: tap_d = tms ? sps_pkg::TAP_EX1_DR : sps_pkg::TAP_SH_DR;
      sps_pkg::TAP_SH_DR:  tap_d = tms ? sps_pkg::TAP_EX1_DR : sps_pkg::TAP_SH_DR;
      sps_pkg::TAP_EX1_DR: tap_d = tms ? sps_pkg::TAP_UPD_DR : sps_pkg::TAP_PA_DR;
      sps_pkg::TAP_PA_DR:  tap_d = tms ? sps_pkg::TAP_EX2_DR : sps_pkg::TAP_PA_DR;
      sps_pkg::TAP_EX2_DR: tap_d = tms ? sps_pkg::TAP_UPD_DR : sps_pkg::TAP_SH_DR;
      sps_pkg::TAP_UPD_DR: tap_d = tms ? sps_pkg::TAP_SEL_DR : sps_pkg::TAP_IDLE;
      sps_pkg::TAP_SEL_IR: tap_d = tms ? sps_pkg::TAP_RESET  : sps_pkg::TAP_CAP_IR;
      sps_pkg::TAP_CAP_IR: tap_d = tms ? sps_pkg::TAP_EX1_IR : sps_pkg::TAP_SH_IR;
      sps_pkg::TAP_SH_IR:  tap_d = tms ? sps_pkg::TAP_EX1_IR : sps_pkg::TAP_SH_IR;
      sps_pkg::TAP_EX1_IR: tap_d = tms ? sps_pkg::TAP_UPD_IR : sps_pkg::TAP_PA_IR;
      sps_pkg::TAP_PA_IR:  tap_d = tms ? sps_pkg::TAP_EX2_IR : sps_pkg::TAP_PA_IR;
      sps_pkg::TAP_EX2_IR: tap_d = tms ? sps_pkg::TAP_UPD_IR : sps_pkg::TAP_SH_IR;
      sps_pkg::TAP_UPD_IR: tap_d = tms ? sps_pkg::TAP_SEL_DR : sps_pkg::TAP_IDLE;
      default:             tap_d = sps_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_q <= 1'b0;
      tap_q <= sps_pkg::TAP_RESET;
      byp_q <= 1'b0;
      tdo   <= 1'b0;
    end else begin
      tck_q <= tck;
      if (tck_rise) begin
        tap_q <= tap_d;
        if (tap_q == sps_pkg::TAP_SH_DR || tap_q == sps_pkg::TAP_SH_IR) begin
          byp_q <= tdi;
        end
      end
      if (tck_fall) begin
        tdo <= byp_q;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       take;

  assign take = hsel && hready && htrans == sps_pkg::HTRANS_NONSEQ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= sps_pkg::HRESP_OKAY;
      hrdata    <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= sps_pkg::HRESP_OKAY;
      wr_pend_q <= take && hwrite && hsize == sps_pkg::HSIZE_WORD;
      wr_addr_q <= haddr;
      if (take && !hwrite) begin
        unique case (haddr)
          sps_pkg::REG_CTRL:   hrdata <= {30'h0, ctrl_q};
          sps_pkg::REG_STATUS: hrdata <= {26'h0, data_oe, burst_q, cnt_q,
                                          mode_q, sleeping};
          sps_pkg::REG_WRCNT:  hrdata <= wrcnt_q;
          default:             hrdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= sps_pkg::CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == sps_pkg::REG_CTRL) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrcnt_q <= 32'h0;
    end else if (wr_pend_q && wr_addr_q == sps_pkg::REG_WRCNT) begin
      wrcnt_q <= hwdata;
    end else if (act && b_wr_q) begin
      wrcnt_q <= wrcnt_q + 32'h1;
    end
  end

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  oe_block_a: assert property (
    oe_n |=> !data_oe && !parity_oe)
    else $error("data driven while output enable high");
  wr_tristate_a: assert property (
    act && a_valid_q && a_write_q |=> !data_oe)
    else $error("data driven during write data phase");
  deselect_off_a: assert property (
    act && !a_valid_q && !burst_q |=> !data_oe)
    else $error("data driven while deselected");
  stall_hold_a: assert property (
    clk_qualify_n |=> $stable(a_addr_q) && $stable(cnt_q) && $stable(b_wr_q))
    else $error("state moved on a masked edge");
  stall_keep_a: assert property (
    (a_valid_q && clk_qualify_n) [*3] |=> a_valid_q)
    else $error("stretched cycle lost its access");
  read_drive_a: assert property (
    act && a_valid_q && !a_write_q && !oe_n && !sleeping
      && !ctrl_q[sps_pkg::CTRL_NODRV] |=> data_oe)
    else $error("read data not driven one cycle after access");
  parity_same_a: assert property (
    parity_oe == data_oe)
    else $error("parity direction differs from data");
  burst_step_a: assert property (
    act && !load && burst_q |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("burst counter did not step");
  strap_float_a: assert property (
    !strap_done_q && !mode_tied |=> mode_q)
    else $error("floating strap not interleaved");
  tdo_fall_a: assert property (
    tdo != $past(tdo) |-> $past(tck_fall))
    else $error("test output changed off a falling edge");
  tap_rise_a: assert property (
    !tck_rise |=> tap_q == $past(tap_q))
    else $error("test state moved without rising edge");
  sleep_quiet_a: assert property (
    sleep_req ##1 sleep_req |-> !data_oe && $stable(a_addr_q))
    else $error("device active while asleep");

  read_seen_c: cover property (act && a_valid_q && !a_write_q ##1 data_oe);
  write_seen_c: cover property (act && b_wr_q && !b_bw_q[0]);
  wrap_seen_c: cover property (act && !load && burst_q && cnt_q == 2'h3);
  stall_seen_c: cover property ((a_valid_q && clk_qualify_n) [*2]);
endmodule // sps_sram_core
`default_nettype wire

/* File: tb/sps_ctrl_model.sv */
// Far-side controller model that owns the shared data and parity lines.
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl_model (
  // Clock
  input  wire logic        hclk,
  // Device side
  input  wire logic [63:0] data_o,
  input  wire logic        data_oe,
  input  wire logic [7:0]  parity_o,
  input  wire logic        parity_oe,
  output logic      [63:0] data_i,
  output logic      [7:0]  parity_i,
  // Bench side
  input  wire logic        wr_en,
  input  wire logic [71:0] wr_word
);
  logic [71:0] last_q = '0;
  // A released line shows the inverse of its last level, never a stale copy.
  always_comb begin
    {parity_i, data_i} = ~last_q;
    if (wr_en) begin
      {parity_i, data_i} = wr_word;
    end
    if (data_oe) begin
      data_i = data_o;
    end
    if (parity_oe) begin
      parity_i = parity_o;
    end
  end
  always_ff @(posedge hclk) begin
    last_q <= {parity_i, data_i};
  end
endmodule // sps_ctrl_model
`default_nettype wire

/* File: tb/sram_pin_io_control_tb_top.sv */
// Self-checking bench for the burst SRAM pin control core.
`timescale 1ns/1ps
`default_nettype none
module sram_pin_io_control_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, byte_lane_write_n, parity_i, parity_o, bw;
  logic [1:0]  htrans, oe;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd32;
  logic        clk_qualify_n, advance_or_load, we_n, ce1_n, oe_n, wr_en;
  logic        sleep_req, mode_tied, mode_level, tck, tms, tdi, tdo;
  logic        data_oe, parity_oe, t0, t1, tprev, tb_bit;
  logic [18:0] addr, a, b, base;
  logic [63:0] data_i, data_o;
  logic [71:0] wr_word, rd, wa, wb, wx[4];
  int          n_errors, tests_run, seed, cyc;

  sps_sram_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_qualify_n(clk_qualify_n),
    .advance_or_load(advance_or_load), .we_n(we_n), .ce1_n(ce1_n),
    .ce2(1'b1), .ce3_n(1'b0), .addr(addr),
    .byte_lane_write_n(byte_lane_write_n), .oe_n(oe_n),
    .sleep_req(sleep_req), .mode_tied(mode_tied), .mode_level(mode_level),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
    .parity_i(parity_i), .parity_o(parity_o), .parity_oe(parity_oe),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  sps_ctrl_model u_far (.hclk(hclk), .data_o(data_o), .data_oe(data_oe),
    .parity_o(parity_o), .parity_oe(parity_oe), .data_i(data_i),
    .parity_i(parity_i), .wr_en(wr_en), .wr_word(wr_word));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input logic [71:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [71:0] rnd72();
    return 72'({$random(seed), $random(seed), $random(seed)});
  endfunction

  function automatic logic [71:0] merge(logic [71:0] o, n, logic [7:0] m);
    merge = o;
    for (int k = 0; k < 8; k++) begin
      if (!m[k]) begin
        merge[8*k+:8] = n[8*k+:8];
        merge[64+k] = n[64+k];
      end
    end
  endfunction

  function automatic logic [18:0] baddr(logic [18:0] s, logic [1:0] j,
                                        logic il);
    baddr = s;
    baddr[1:0] = il ? (s[1:0] ^ j) : (s[1:0] + j);
  endfunction

  task automatic do_reset(input logic tied, input logic lvl);
    hresetn <= 1'b0;
    mode_tied <= tied;
    mode_level <= lvl;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    htrans <= sps_pkg::HTRANS_NONSEQ;
    haddr <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd32 = hrdata;
    chk(72'(hresp), 72'(sps_pkg::HRESP_OKAY), "bus response");
  endtask

  task automatic mem_op(input logic w, input logic [18:0] ad,
                        input logic [71:0] d, input logic [7:0] m);
    advance_or_load <= 1'b0;
    ce1_n <= 1'b0;
    we_n <= !w;
    addr <= ad;
    byte_lane_write_n <= m;
    @(posedge hclk);
    ce1_n <= 1'b1;
    // Read data and the write data phase both open one edge later.
    @(posedge hclk);
    wr_en <= w;
    wr_word <= d;
    @(negedge hclk);
    rd = {parity_o, data_o};
    oe = {parity_oe, data_oe};
    @(posedge hclk);
    wr_en <= 1'b0;
  endtask

  // Four-beat write burst from an index of 2 or 3, then single reads of each beat.
  task automatic burst(input logic il);
    base = 19'($random(seed)) | 19'h2;
    // Beat k is latched two active edges after its address edge.
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        wx[i] = rnd72();
      end
      advance_or_load <= (i > 0 && i < 4);
      ce1_n <= (i >= 4);
      we_n <= 1'b0;
      addr <= base;
      byte_lane_write_n <= 8'h00;
      wr_en <= (i >= 2);
      wr_word <= wx[(i >= 2) ? i - 2 : 0];
      @(posedge hclk);
    end
    wr_en <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      mem_op(1'b0, baddr(base, 2'(j), il), '0, 8'hff);
      chk(rd, wx[j], "burst beat");
    end
  endtask

  task automatic tap(input logic m, d, output logic pre, post);
    tms <= m;
    tdi <= d;
    tck <= 1'b1;
    repeat (6) @(posedge hclk);
    pre = tdo;
    tck <= 1'b0;
    repeat (6) @(posedge hclk);
    post = tdo;
  endtask

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, tck, tms, tdi} = '0;
    {we_n, ce1_n, advance_or_load, addr, wr_en, wr_word} = '0;
    {mode_tied, mode_level, sleep_req, clk_qualify_n, oe_n} = '0;
    byte_lane_write_n = 8'hff;
    hsize = sps_pkg::HSIZE_WORD;
    hsel = 1'b1;
    seed = 40374;
    do_reset(1'b0, 1'b0);
    ahb(1'b0, sps_pkg::REG_STATUS, '0);
    chk(72'(rd32[sps_pkg::ST_ILEAVE]), 72'h1, "floating strap");
    ahb(1'b0, 8'h40, '0);
    chk(72'(rd32), 72'h0, "unmapped read");
    ahb(1'b1, sps_pkg::REG_WRCNT, 32'h5a);
    ahb(1'b0, sps_pkg::REG_WRCNT, '0);
    chk(72'(rd32), 72'h5a, "counter write");
    a = 19'($random(seed));
    b = a ^ 19'h10;
    wa = rnd72();
    wb = rnd72();
    mem_op(1'b1, a, wa, 8'h00);
    chk(72'(oe), 72'h0, "write data phase");
    mem_op(1'b1, b, wb, 8'h00);
    mem_op(1'b0, a, '0, 8'hff);
    chk(rd, wa, "read data");
    chk(72'(oe), 72'h3, "read drive");
    oe_n <= 1'b1;
    mem_op(1'b0, b, '0, 8'hff);
    chk(72'(oe), 72'h0, "output enable high");
    oe_n <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(72'({parity_oe, data_oe}), 72'h0, "deselected drive");
    chk(72'(data_oe), 72'h0, "deselected drive");
    bw = 8'($random(seed));
    wx[0] = rnd72();
    @(posedge hclk);
    mem_op(1'b1, a, wx[0], bw);
    wa = merge(wa, wx[0], bw);
    mem_op(1'b0, a, '0, 8'hff);
    chk(rd, wa, "lane write");
    advance_or_load <= 1'b0;
    ce1_n <= 1'b0;
    we_n <= 1'b1;
    addr <= b;
    @(posedge hclk);
    ce1_n <= 1'b1;
    clk_qualify_n <= 1'b1;
    repeat (3) @(posedge hclk);
    clk_qualify_n <= 1'b0;
    @(negedge hclk);
    chk({parity_o, data_o}, wa, "stalled edge");
    @(posedge hclk);
    @(negedge hclk);
    chk({parity_o, data_o}, wb, "stretched read");
    @(posedge hclk);
    sleep_req <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, sps_pkg::REG_STATUS, '0);
    chk(72'(rd32[sps_pkg::ST_SLEEP]), 72'h1, "sleep flag");
    chk(72'(data_oe), 72'h0, "sleep drive");
    sleep_req <= 1'b0;
    @(posedge hclk);
    mem_op(1'b0, a, '0, 8'hff);
    chk(rd, wa, "contents kept");
    burst(1'b1);
    for (int i = 8; i >= 0; i--) begin
      tap(9'b111110100 >> i, 1'b0, t0, t1);
    end
    tprev = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tb_bit = 1'($random(seed));
      tap(1'b0, tb_bit, t0, t1);
      chk(72'(t0), 72'(tprev), "serial out before fall");
      chk(72'(t1), 72'(tb_bit), "serial in shifted");
      tprev = tb_bit;
    end
    do_reset(1'b1, 1'b0);
    ahb(1'b0, sps_pkg::REG_STATUS, '0);
    chk(72'(rd32[sps_pkg::ST_ILEAVE]), 72'h0, "strap low");
    burst(1'b0);
    stop_test();
  end
endmodule // sram_pin_io_control_tb_top
`default_nettype wire
